//--- sp0_defines.svh
`ifndef SP0_DEFINES_SVH
`define SP0_DEFINES_SVH

// Register addresses.
`define SP0_ADDR_DATA   16'h0099
`define SP0_ADDR_CTRL   16'h009b
`define SP0_ADDR_BAUD   16'h009d
`define SP0_ADDR_RELOAD 16'h009e
`define SP0_ADDR_ROUTE  16'hfff1

// Reset values.
`define SP0_CTRL_RST    8'h00
`define SP0_ROUTE_RST   8'h00
`define SP0_BAUD_RST    8'h00
`define SP0_RELOAD_RST  8'h00

// Control register fields.
`define SP0_CTRL_RI     0
`define SP0_CTRL_TI     1
`define SP0_CTRL_RB8    2
`define SP0_CTRL_TB8    3
`define SP0_CTRL_REN    4
`define SP0_CTRL_SM2    5
`define SP0_CTRL_MLO    6
`define SP0_CTRL_MHI    7

// Pin routing and baud control fields.
`define SP0_ROUTE_SEL   0
`define SP0_ROUTE_LPBK  1
`define SP0_BAUD_SMOD   6
`define SP0_BAUD_BAUD_SOURCE_SELECT   7

// Timing counts.
`define SP0_M0_LAST     4'd11
`define SP0_M0_HALF     4'd6
`define SP0_OS_LAST     4'd15
`define SP0_OS_MID      4'd7
`define SP0_BRG_TOP     8'hff

// Frame lengths in bits.
`define SP0_BITS_M0     4'd8
`define SP0_BITS_M1     4'd10
`define SP0_BITS_M23    4'd11

`endif

//--- sp0_pkg.sv
package sp0_pkg;
    typedef enum logic [1:0] {
        SP0_MODE_SHIFT = 2'b00,
        SP0_MODE_UART8 = 2'b01,
        SP0_MODE_FIX9  = 2'b10,
        SP0_MODE_VAR9  = 2'b11
    } sp0_mode_t;

    typedef enum logic [1:0] {
        SP0_RX_IDLE  = 2'b00,
        SP0_RX_START = 2'b01,
        SP0_RX_DATA  = 2'b10,
        SP0_RX_STOP  = 2'b11
    } sp0_rx_state_t;
endpackage

//--- sp0_baud.sv
`timescale 1ns/1ns
`include "sp0_defines.svh"
module sp0_baud (
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  sp0_pkg::sp0_mode_t     mode_i,
    input  wire logic              baud_source_select_i,
    input  wire logic              smod_i,
    input  wire logic [7:0]        reload_i,
    input  wire logic              t1_tick_i,
    output logic                   tick_o
);
    import sp0_pkg::*;

    logic       div2_q;
    logic       pre_q;
    logic [7:0] brg_q;
    logic       raw;
    logic       m2_slow;

    assign m2_slow = (mode_i == SP0_MODE_FIX9) && !smod_i;

    // Oversampling tick source, sixteen ticks per bit.
    always_comb begin
        unique case (mode_i)
            SP0_MODE_SHIFT: raw = 1'b0;
            SP0_MODE_FIX9:  raw = div2_q;
            SP0_MODE_UART8,
            SP0_MODE_VAR9:  raw = baud_source_select_i ? (brg_q == `SP0_BRG_TOP) : t1_tick_i;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div2_q <= 1'b0;
        end else begin
            div2_q <= ~div2_q;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            brg_q <= 8'h00;
        end else if (brg_q == `SP0_BRG_TOP) begin
            brg_q <= reload_i;
        end else begin
            brg_q <= brg_q + 8'h01;
        end
    end

    // The doubler skips the halving stage.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_q  <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            pre_q  <= raw ? ~pre_q : pre_q;
            tick_o <= raw & (smod_i | pre_q);
        end
    end

    property p_m2_slow;
        @(posedge mclk_i) disable iff (!rstn_i)
        // A configuration change ends the spacing check, since the new source may tick at once.
        m2_slow && $stable(smod_i) && $stable(mode_i) && tick_o
        |=> (!tick_o || !m2_slow) [*3] ##1 (tick_o || !m2_slow);
    endproperty
    a_m2_slow: assert property (p_m2_slow) else $error("mode 2 slow tick spacing wrong");
endmodule

//--- sp0_top.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`include "sp0_defines.svh"
module sp0_top #(
    parameter int ADDR_W = 16
) (
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [7:0]             rdata_o,
    input  wire logic              t1_tick_i,
    input  wire logic              eng1_txd_i,
    output logic                   eng1_rxd_o,
    output logic                   txd_o,
    input  wire logic              rxd_i,
    output logic                   rxd_o,
    output logic                   rxd_oe_o,
    output sp0_pkg::sp0_mode_t     mode_o
);
    import sp0_pkg::*;

    generate
        if (ADDR_W < 16) begin : g_chk
            $error("ADDR_W must be at least 16");
        end
    endgenerate

    logic [7:0]    route_q;
    logic [7:0]    baud_q;
    logic [7:0]    reload_q;
    sp0_mode_t     mode_q;
    logic          sm2_q;
    logic          ren_q;
    logic          tb8_q;
    logic          rb8_q;
    logic          ti_q;
    logic          ri_q;
    logic [7:0]    rxbuf_q;
    logic          s1_q;
    logic          s2_q;
    logic          s3_q;
    logic          pin_rx_q;
    logic          tx_busy_q;
    logic          m0_rx_q;
    logic [10:0]   tx_sh_q;
    logic [3:0]    tx_left_q;
    logic [3:0]    tx_os_q;
    logic [3:0]    m0_cnt_q;
    logic          tx_done_q;
    logic          m0_done_q;
    sp0_rx_state_t rx_st_q;
    logic [3:0]    rx_os_q;
    logic [3:0]    rx_cnt_q;
    logic [8:0]    rx_sh_q;
    logic          rx_done_q;
    logic [7:0]    rx_data_q;
    logic          rx_ninth_q;
    logic          tick;
    logic          sel;
    logic          lpbk;
    logic          nine;
    logic          sclk;
    logic          tx0_line;
    logic          rx0_in;
    logic          wr_data;
    logic          tx_start;
    logic          m0_rx_start;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] reg_addr);
        hit = (a == ADDR_W'(reg_addr));
    endfunction

    function automatic logic [3:0] frame_bits(input sp0_mode_t m);
        unique case (m)
            SP0_MODE_SHIFT: frame_bits = `SP0_BITS_M0;
            SP0_MODE_UART8: frame_bits = `SP0_BITS_M1;
            SP0_MODE_FIX9,
            SP0_MODE_VAR9:  frame_bits = `SP0_BITS_M23;
        endcase
    endfunction

    assign sel         = route_q[`SP0_ROUTE_SEL];
    assign lpbk        = route_q[`SP0_ROUTE_LPBK];
    assign nine        = mode_q[1];
    assign mode_o      = mode_q;
    assign wr_data     = wr_i && hit(addr_i, `SP0_ADDR_DATA);
    assign tx_start    = wr_data && !tx_busy_q;
    assign m0_rx_start = (mode_q == SP0_MODE_SHIFT) && ren_q && !ri_q && !tx_busy_q && !m0_done_q && !tx_start;
    assign sclk        = !(tx_busy_q && (mode_q == SP0_MODE_SHIFT) && (m0_cnt_q < `SP0_M0_HALF));
    assign tx0_line    = (mode_q == SP0_MODE_SHIFT) ? sclk : (tx_busy_q ? tx_sh_q[0] : 1'b1);

    // Engine 0 receive source; idle high when it is not connected.
    always_comb begin
        if (lpbk) begin
            rx0_in = sel ? eng1_txd_i : 1'b1;
        end else begin
            rx0_in = sel ? 1'b1 : pin_rx_q;
        end
    end

    sp0_baud u_baud (
        .mclk_i    (mclk_i),
        .rstn_i    (rstn_i),
        .mode_i    (mode_q),
        .baud_source_select_i    (baud_q[`SP0_BAUD_BAUD_SOURCE_SELECT]),
        .smod_i    (baud_q[`SP0_BAUD_SMOD]),
        .reload_i  (reload_q),
        .t1_tick_i (t1_tick_i),
        .tick_o    (tick)
    );

    // Receive pin synchroniser; a level is taken once stages two and three agree.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_q     <= 1'b1;
            s2_q     <= 1'b1;
            s3_q     <= 1'b1;
            pin_rx_q <= 1'b1;
        end else begin
            s1_q     <= rxd_i;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            pin_rx_q <= (s2_q == s3_q) ? s3_q : pin_rx_q;
        end
    end

    // Pin drivers; only the selected engine reaches the transmit pin.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            txd_o      <= 1'b1;
            eng1_rxd_o <= 1'b1;
            rxd_o      <= 1'b1;
            rxd_oe_o   <= 1'b0;
        end else begin
            txd_o      <= sel ? eng1_txd_i : tx0_line;
            eng1_rxd_o <= lpbk ? (sel ? 1'b1 : tx0_line) : (sel ? pin_rx_q : 1'b1);
            rxd_o      <= tx_sh_q[0];
            rxd_oe_o   <= !sel && !lpbk && tx_busy_q && !m0_rx_q && (mode_q == SP0_MODE_SHIFT);
        end
    end

    // Configuration registers.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            route_q  <= `SP0_ROUTE_RST;
            baud_q   <= `SP0_BAUD_RST;
            reload_q <= `SP0_RELOAD_RST;
        end else if (wr_i) begin
            route_q  <= hit(addr_i, `SP0_ADDR_ROUTE) ? wdata_i : route_q;
            baud_q   <= hit(addr_i, `SP0_ADDR_BAUD) ? wdata_i : baud_q;
            reload_q <= hit(addr_i, `SP0_ADDR_RELOAD) ? wdata_i : reload_q;
        end
    end

    // Serial control register; hardware sets win over a software clear.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_q <= SP0_MODE_SHIFT;
            sm2_q  <= 1'b0;
            ren_q  <= 1'b0;
            tb8_q  <= 1'b0;
            rb8_q  <= 1'b0;
            ti_q   <= 1'b0;
            ri_q   <= 1'b0;
        end else begin
            if (wr_i && hit(addr_i, `SP0_ADDR_CTRL)) begin
                mode_q <= sp0_mode_t'({wdata_i[`SP0_CTRL_MHI], wdata_i[`SP0_CTRL_MLO]});
                sm2_q  <= wdata_i[`SP0_CTRL_SM2];
                ren_q  <= wdata_i[`SP0_CTRL_REN];
                tb8_q  <= wdata_i[`SP0_CTRL_TB8];
                rb8_q  <= rx_done_q ? rx_ninth_q : wdata_i[`SP0_CTRL_RB8];
                ti_q   <= wdata_i[`SP0_CTRL_TI] | tx_done_q;
                ri_q   <= wdata_i[`SP0_CTRL_RI] | rx_done_q | m0_done_q;
            end else begin
                rb8_q  <= rx_done_q ? rx_ninth_q : rb8_q;
                ti_q   <= ti_q | tx_done_q;
                ri_q   <= ri_q | rx_done_q | m0_done_q;
            end
        end
    end

    // Received character buffer.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rxbuf_q <= 8'h00;
        end else if (m0_done_q) begin
            rxbuf_q <= tx_sh_q[7:0];
        end else if (rx_done_q) begin
            rxbuf_q <= rx_data_q;
        end
    end

    // Read port; data stand only in the cycle after the strobe.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (!rd_i) begin
            rdata_o <= 8'h00;
        end else if (hit(addr_i, `SP0_ADDR_DATA)) begin
            rdata_o <= rxbuf_q;
        end else if (hit(addr_i, `SP0_ADDR_CTRL)) begin
            rdata_o <= {mode_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
        end else if (hit(addr_i, `SP0_ADDR_ROUTE)) begin
            rdata_o <= route_q;
        end else if (hit(addr_i, `SP0_ADDR_BAUD)) begin
            rdata_o <= baud_q;
        end else if (hit(addr_i, `SP0_ADDR_RELOAD)) begin
            rdata_o <= reload_q;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Transmitter, also the shift-mode shifter in both directions.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_busy_q <= 1'b0;
            m0_rx_q   <= 1'b0;
            tx_sh_q   <= 11'h7ff;
            tx_left_q <= 4'd0;
            tx_os_q   <= 4'd0;
            m0_cnt_q  <= 4'd0;
            tx_done_q <= 1'b0;
            m0_done_q <= 1'b0;
        end else begin
            tx_done_q <= 1'b0;
            m0_done_q <= 1'b0;
            if (tx_start || m0_rx_start) begin
                tx_busy_q <= 1'b1;
                m0_rx_q   <= m0_rx_start;
                tx_left_q <= frame_bits(mode_q);
                tx_os_q   <= 4'd0;
                m0_cnt_q  <= 4'd0;
                if (mode_q == SP0_MODE_SHIFT) begin
                    tx_sh_q <= {3'b111, wdata_i};
                end else begin
                    tx_sh_q <= {1'b1, nine ? tb8_q : 1'b1, wdata_i, 1'b0};
                end
            end else if (tx_busy_q && (mode_q == SP0_MODE_SHIFT)) begin
                m0_cnt_q <= (m0_cnt_q == `SP0_M0_LAST) ? 4'd0 : m0_cnt_q + 4'd1;
                if (m0_cnt_q == `SP0_M0_LAST) begin
                    tx_sh_q[7:0] <= {rx0_in, tx_sh_q[7:1]};
                    tx_left_q    <= tx_left_q - 4'd1;
                    if (tx_left_q == 4'd1) begin
                        tx_busy_q <= 1'b0;
                        tx_done_q <= !m0_rx_q;
                        m0_done_q <= m0_rx_q;
                    end
                end
            end else if (tx_busy_q && tick) begin
                tx_os_q <= tx_os_q + 4'd1;
                if (tx_os_q == `SP0_OS_LAST) begin
                    tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                    tx_left_q <= tx_left_q - 4'd1;
                    if (tx_left_q == 4'd1) begin
                        tx_busy_q <= 1'b0;
                        tx_done_q <= 1'b1;
                    end
                end
            end
        end
    end

    // Asynchronous receiver with start-bit check at mid bit.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_st_q    <= SP0_RX_IDLE;
            rx_os_q    <= 4'd0;
            rx_cnt_q   <= 4'd0;
            rx_sh_q    <= 9'h000;
            rx_done_q  <= 1'b0;
            rx_data_q  <= 8'h00;
            rx_ninth_q <= 1'b0;
        end else begin
            rx_done_q <= 1'b0;
            if (mode_q == SP0_MODE_SHIFT) begin
                rx_st_q <= SP0_RX_IDLE;
            end else if (tick) begin
                rx_os_q <= rx_os_q + 4'd1;
                unique case (rx_st_q)
                    SP0_RX_IDLE: begin
                        rx_os_q <= 4'd0;
                        if (ren_q && !rx0_in) begin
                            rx_st_q <= SP0_RX_START;
                        end
                    end
                    SP0_RX_START: begin
                        if (rx_os_q == `SP0_OS_MID) begin
                            rx_os_q  <= 4'd0;
                            rx_cnt_q <= 4'd0;
                            rx_st_q  <= rx0_in ? SP0_RX_IDLE : SP0_RX_DATA;
                        end
                    end
                    SP0_RX_DATA: begin
                        if (rx_os_q == `SP0_OS_LAST) begin
                            rx_sh_q  <= {rx0_in, rx_sh_q[8:1]};
                            rx_cnt_q <= rx_cnt_q + 4'd1;
                            if (rx_cnt_q == (nine ? 4'd8 : 4'd7)) begin
                                rx_st_q <= SP0_RX_STOP;
                            end
                        end
                    end
                    SP0_RX_STOP: begin
                        if (rx_os_q == `SP0_OS_LAST) begin
                            rx_st_q    <= SP0_RX_IDLE;
                            rx_done_q  <= 1'b1;
                            rx_data_q  <= nine ? rx_sh_q[7:0] : rx_sh_q[8:1];
                            rx_ninth_q <= nine ? rx_sh_q[8] : rx0_in;
                        end
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_route_sel0;
        !sel |=> txd_o == $past(tx0_line);
    endproperty
    a_route_sel0: assert property (p_route_sel0) else $error("engine 0 not on transmit pin");

    property p_route_sel1;
        sel |=> txd_o == $past(eng1_txd_i);
    endproperty
    a_route_sel1: assert property (p_route_sel1) else $error("engine 1 not on transmit pin");

    property p_loop0;
        lpbk && !sel |=> eng1_rxd_o == $past(tx0_line);
    endproperty
    a_loop0: assert property (p_loop0) else $error("loop-back 0 to 1 broken");

    property p_idle_rx;
        !lpbk && sel |-> rx0_in;
    endproperty
    a_idle_rx: assert property (p_idle_rx) else $error("unselected receive not idle");

    property p_sclk_half;
        $fell(sclk) |-> !sclk [*6] ##1 sclk;
    endproperty
    a_sclk_half: assert property (p_sclk_half) else $error("shift clock low phase wrong");

    property p_m0_rx_start;
        m0_rx_start |=> tx_busy_q && m0_rx_q && tx_left_q == `SP0_BITS_M0;
    endproperty
    a_m0_rx_start: assert property (p_m0_rx_start) else $error("shift receive did not start");

    property p_start_bit;
        tx_start && (mode_q != SP0_MODE_SHIFT) |=> !tx0_line && tx_left_q == frame_bits(mode_q);
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("frame start wrong");

    property p_ninth_tx;
        tx_start && nine |=> tx_sh_q[9] == $past(tb8_q);
    endproperty
    a_ninth_tx: assert property (p_ninth_tx) else $error("ninth bit not loaded");

    property p_ti_set;
        tx_done_q |=> ti_q;
    endproperty
    a_ti_set: assert property (p_ti_set) else $error("transmit flag not set");

    property p_ren_off;
        !ren_q && rx_st_q == SP0_RX_IDLE |=> rx_st_q == SP0_RX_IDLE;
    endproperty
    a_ren_off: assert property (p_ren_off) else $error("reception while disabled");

    property p_rx_buf;
        rx_done_q |=> rxbuf_q == $past(rx_data_q) && rb8_q == $past(rx_ninth_q);
    endproperty
    a_rx_buf: assert property (p_rx_buf) else $error("received character not stored");
endmodule

//--- sp0_host_model.sv
`timescale 1ns/1ns
module sp0_host_model (
    input  wire logic mclk_i,
    input  wire logic txd_i,
    input  wire logic tie_i,
    output logic      rxd_o
);
    logic drv_q;

    // The fixture strap joins both pins when the loop-back test is running.
    assign rxd_o = tie_i ? txd_i : drv_q;

    initial drv_q = 1'b1;

    task automatic send(input logic [10:0] bits, input int n, input int p);
        for (int i = 0; i < n; i++) begin
            drv_q <= bits[i];
            repeat (p) @(posedge mclk_i);
        end
        drv_q <= 1'b1;
    endtask

    // Waits for a start bit, then samples each bit at its middle.
    task automatic grab(input int n, input int p, output logic [10:0] bits, output logic ok);
        int k;
        bits = '0;
        k = 0;
        while (txd_i !== 1'b0 && k < 4000) begin
            @(posedge mclk_i);
            k++;
        end
        ok = (k < 4000);
        repeat (p / 2) @(posedge mclk_i);
        for (int i = 0; i < n; i++) begin
            bits[i] = txd_i;
            repeat (p) @(posedge mclk_i);
        end
    endtask

    // Drives one shift-mode character, each bit just after the shift clock falls.
    task automatic shift_in(input logic [7:0] d, output logic ok);
        int w;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            w = 0;
            while (txd_i !== 1'b0 && w < 40) begin
                @(posedge mclk_i);
                w++;
            end
            ok = ok && (w < 40);
            drv_q <= d[i];
            w = 0;
            while (txd_i !== 1'b1 && w < 40) begin
                @(posedge mclk_i);
                w++;
            end
        end
    endtask
endmodule

//--- sp0_top_bench.sv
`timescale 1ns/1ns
`include "sp0_defines.svh"
module sp0_top_bench;
    import sp0_pkg::*;
    logic              mclk_i;
    logic              rstn_i;
    logic [15:0]       addr_i;
    logic [7:0]        wdata_i;
    logic              wr_i;
    logic              rd_i;
    logic [7:0]        rdata_o;
    logic [7:0]        rd_v;
    logic              t1_tick_i;
    logic              t1_run;
    logic              eng1_txd_i;
    logic              eng1_rxd_o;
    logic              txd_o;
    logic              rxd_o;
    logic              rxd_oe_o;
    logic              host_line;
    logic              rxd_pin;
    logic              tie;
    logic              ok;
    logic [10:0]       fr;
    sp0_mode_t         mode_o;
    int                n_errors;
    int                comparisons;
    int                k;

    assign rxd_pin = rxd_oe_o ? rxd_o : host_line;

    sp0_top #(.ADDR_W(16)) uut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .t1_tick_i(t1_tick_i),
        .eng1_txd_i(eng1_txd_i), .eng1_rxd_o(eng1_rxd_o), .txd_o(txd_o),
        .rxd_i(rxd_pin), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .mode_o(mode_o)
    );

    sp0_host_model host (.mclk_i(mclk_i), .txd_i(txd_o), .tie_i(tie), .rxd_o(host_line));

    // Timer 1 overflow pulses every second clock while enabled.
    always @(posedge mclk_i) begin
        t1_tick_i <= t1_run & ~t1_tick_i;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1 rd_v = rdata_o;
        chk(nm, {3'h0, e}, {3'h0, rd_v});
    endtask

    task automatic txchk(input string nm, input int n, input logic [10:0] e);
        host.grab(n, 32, fr, ok);
        chk(nm, 11'h1, {10'h0, ok});
        chk(nm, e, fr);
    endtask

    task automatic wlow();
        k = 0;
        while (txd_o !== 1'b0 && k < 400) begin
            @(posedge mclk_i);
            k++;
        end
        chk("start", 11'h1, {10'h0, k < 400});
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    initial begin
        repeat (60000) @(posedge mclk_i);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        rstn_i = 1'b0;
        addr_i = 16'h0000;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        t1_run = 1'b0;
        t1_tick_i = 1'b0;
        eng1_txd_i = 1'b1;
        tie = 1'b0;
        n_errors = 0;
        comparisons = 0;
        repeat (2) @(posedge mclk_i);
        rstn_i <= 1'b1;
        rchk("ctrl", `SP0_ADDR_CTRL, 8'h00);
        rchk("route", `SP0_ADDR_ROUTE, 8'h00);
        wr(16'h0123, 8'hff);
        rchk("unmapped", 16'h0123, 8'h00);
        chk("eng1 rx idle", 11'h1, {10'h0, eng1_rxd_o});
        wr(`SP0_ADDR_BAUD, 8'h40);
        wr(`SP0_ADDR_RELOAD, 8'hfe);
        wr(`SP0_ADDR_CTRL, 8'h98);
        wr(`SP0_ADDR_DATA, 8'ha5);
        chk("mode", {9'h0, SP0_MODE_FIX9}, {9'h0, mode_o});
        txchk("m2 tx", 11, {2'b11, 8'ha5, 1'b0});
        repeat (40) @(posedge mclk_i);
        rchk("ti", `SP0_ADDR_CTRL, 8'h9a);
        wr(`SP0_ADDR_CTRL, 8'h98);
        host.send({2'b11, 8'h3c, 1'b0}, 11, 32);
        repeat (40) @(posedge mclk_i);
        rchk("m2 rx ctrl", `SP0_ADDR_CTRL, 8'h9d);
        rchk("m2 rx data", `SP0_ADDR_DATA, 8'h3c);
        wr(`SP0_ADDR_BAUD, 8'h00);
        wr(`SP0_ADDR_CTRL, 8'h88);
        host.send({2'b11, 8'h55, 1'b0}, 11, 32);
        repeat (40) @(posedge mclk_i);
        rchk("rx off ctrl", `SP0_ADDR_CTRL, 8'h88);
        rchk("rx off data", `SP0_ADDR_DATA, 8'h3c);
        wr(`SP0_ADDR_BAUD, 8'h40);
        t1_run <= 1'b1;
        wr(`SP0_ADDR_CTRL, 8'h50);
        wr(`SP0_ADDR_DATA, 8'h81);
        txchk("m1 tx", 10, {1'b1, 8'h81, 1'b0});
        repeat (40) @(posedge mclk_i);
        host.send({1'b1, 8'h6e, 1'b0}, 10, 32);
        repeat (40) @(posedge mclk_i);
        rchk("m1 rx ctrl", `SP0_ADDR_CTRL, 8'h57);
        rchk("m1 rx data", `SP0_ADDR_DATA, 8'h6e);
        wr(`SP0_ADDR_BAUD, 8'hc0);
        wr(`SP0_ADDR_CTRL, 8'hc8);
        wr(`SP0_ADDR_DATA, 8'h0f);
        txchk("m3 tx", 11, {2'b11, 8'h0f, 1'b0});
        repeat (40) @(posedge mclk_i);
        t1_run <= 1'b0;
        wr(`SP0_ADDR_CTRL, 8'h00);
        wr(`SP0_ADDR_DATA, 8'h35);
        wlow();
        for (int i = 0; i < 8; i++) begin
            repeat (3) @(posedge mclk_i);
            chk("m0 oe", 11'h1, {10'h0, rxd_oe_o});
            chk("m0 clk low", 11'h0, {10'h0, txd_o});
            repeat (6) @(posedge mclk_i);
            chk("m0 bit", {10'h0, k < 400 && 8'h35 >> i & 8'h01}, {10'h0, rxd_o});
            repeat (3) @(posedge mclk_i);
        end
        repeat (40) @(posedge mclk_i);
        rchk("m0 ti", `SP0_ADDR_CTRL, 8'h02);
        wr(`SP0_ADDR_CTRL, 8'h10);
        host.shift_in(8'h96, ok);
        chk("m0 rx clock", 11'h1, {10'h0, ok});
        repeat (20) @(posedge mclk_i);
        rchk("m0 rx ctrl", `SP0_ADDR_CTRL, 8'h11);
        rchk("m0 rx data", `SP0_ADDR_DATA, 8'h96);
        wr(`SP0_ADDR_ROUTE, 8'h01);
        eng1_txd_i <= 1'b0;
        host.drv_q <= 1'b0;
        repeat (8) @(posedge mclk_i);
        chk("sel1 txd", 11'h0, {10'h0, txd_o});
        chk("sel1 rxd", 11'h0, {10'h0, eng1_rxd_o});
        wr(`SP0_ADDR_ROUTE, 8'h00);
        repeat (8) @(posedge mclk_i);
        chk("sel0 eng1 rx", 11'h1, {10'h0, eng1_rxd_o});
        chk("sel0 txd", 11'h1, {10'h0, txd_o});
        eng1_txd_i <= 1'b1;
        host.drv_q <= 1'b1;
        tie <= 1'b1;
        wr(`SP0_ADDR_ROUTE, 8'h02);
        wr(`SP0_ADDR_CTRL, 8'h90);
        wr(`SP0_ADDR_DATA, 8'h5a);
        wlow();
        repeat (16) @(posedge mclk_i);
        chk("lpbk eng1 rx", 11'h0, {10'h0, eng1_rxd_o});
        repeat (400) @(posedge mclk_i);
        rchk("lpbk ctrl", `SP0_ADDR_CTRL, 8'h92);
        tally_and_finish();
    end
endmodule
